// [hw/adcslp_ctrl.sv]
// module: converter control with sleep-started conversion, result formatting and avalon registers
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
module adcslp_ctrl #(
	parameter int PRESCALE = 2
) (
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_arst_n,
	// avalon-mm slave
	input  wire logic [4:0]         i_address,
	input  wire logic               i_read,
	input  wire logic               i_write,
	input  wire logic [31:0]        i_writedata,
	output logic      [31:0]        o_readdata,
	output logic                    o_waitrequest,
	// cpu and sleep controller
	input  wire logic [2:0]         i_sleep_mode,
	input  wire logic               i_cpu_halted,
	// converter core
	input  wire logic signed [11:0] i_sample_value,
	output logic [1:0]              o_reference_choice,
	output logic [4:0]              o_input_gain_choice,
	output logic                    o_converter_on,
	output logic                    o_converting,
	// interrupt
	output logic                    o_irq
);
	localparam int PW = $clog2(PRESCALE + 1);

	// prescaler must divide by at least one
	generate
		if (PRESCALE < 1) begin : g_bad_prescale
			$error("PRESCALE must be at least 1");
		end
	endgenerate

	// differential codes sit between the single-ended and the fixed-source choices
	function automatic logic adcslp_is_diff(input logic [4:0] mux);
		adcslp_is_diff = (mux >= 5'h08) && (mux <= 5'h1d);
	endfunction : adcslp_is_diff

	// clamp a raw sample into the code range of the chosen input kind
	function automatic logic [9:0] adcslp_format(input logic signed [11:0] v, input logic diff);
		logic signed [11:0] c;
		c = v;
		if (diff) begin
			if (v > adcslp_pkg::DIFF_MAX) c = adcslp_pkg::DIFF_MAX;
			else if (v < adcslp_pkg::DIFF_MIN) c = adcslp_pkg::DIFF_MIN;
		end else begin
			if (v > adcslp_pkg::SE_MAX) c = adcslp_pkg::SE_MAX;
			else if (v < 12'sh000) c = 12'sh000;
		end
		adcslp_format = c[9:0];
	endfunction : adcslp_format

	logic [7:0]                 select_reg;
	logic                       enable;
	logic                       start;
	logic                       free_run;
	logic                       first_conv;
	logic                       sleep_conv;
	logic                       halted_d;
	logic [1:0]                 status;
	logic [1:0]                 irq_en;
	logic [9:0]                 result;
	logic [PW-1:0]              pre_cnt;
	logic [4:0]                 cyc_cnt;
	adcslp_pkg::adcslp_state_t  state;
	adcslp_pkg::adcslp_state_t  next_state;

	// bus decode; an access completes on the cycle waitrequest is low
	wire        req      = i_read | i_write;
	wire        wr_hit   = i_write & ~o_waitrequest;
	wire        wr_sel   = wr_hit && (i_address == adcslp_pkg::OFF_SELECT);
	wire        wr_ctrl  = wr_hit && (i_address == adcslp_pkg::OFF_CONTROL);
	wire        wr_clr   = wr_hit && (i_address == adcslp_pkg::OFF_CLEAR);
	wire        wr_en    = wr_hit && (i_address == adcslp_pkg::OFF_IRQ_EN);
	wire        wd_en    = i_writedata[adcslp_pkg::BIT_ENABLE];

	// converter clock ticks only while enabled; held in reset otherwise
	wire        tick     = enable && (pre_cnt == PW'(PRESCALE - 1));

	// only idle and noise-reduction halts start a conversion, other states change nothing
	wire        quiet    = (i_sleep_mode == adcslp_pkg::SLEEP_IDLE)
	                    || (i_sleep_mode == adcslp_pkg::SLEEP_NOISE);
	wire        halt_up  = i_cpu_halted & ~halted_d;
	wire        sleep_go = quiet && halt_up && enable && !start
	                    && (state == adcslp_pkg::ST_IDLE) && !free_run;
	wire        user_go  = wr_ctrl && wd_en && i_writedata[adcslp_pkg::BIT_START];
	wire        conv_end = (state == adcslp_pkg::ST_CONV) && tick && (cyc_cnt == 5'd0);
	wire        busy     = (state != adcslp_pkg::ST_IDLE);

	// result presentation follows the live adjust bit, not the one at conversion time
	wire        left     = select_reg[adcslp_pkg::BIT_LEFT_ADJUST];
	wire [15:0] view     = left ? {result, 6'h00} : {6'h00, result};

	// completion events; sleep-started completion raises its own bit as well
	wire [1:0]  ev       = {conv_end & sleep_conv, conv_end};
	wire [1:0]  clr_bits = wr_clr ? i_writedata[1:0] : 2'h0;
	wire [1:0]  next_status = (status & ~clr_bits) | ev;

	wire [7:0]  ctrl_word = {enable, start, free_run, status[adcslp_pkg::BIT_EV_DONE],
	                         busy, 3'h0};

	// read mux; unmapped and write-only addresses read zero
	wire [7:0]  rd_byte =
		(i_address == adcslp_pkg::OFF_SELECT)   ? select_reg :
		(i_address == adcslp_pkg::OFF_CONTROL)  ? ctrl_word :
		(i_address == adcslp_pkg::OFF_RES_LOW)  ? view[7:0] :
		(i_address == adcslp_pkg::OFF_RES_HIGH) ? view[15:8] :
		(i_address == adcslp_pkg::OFF_STATUS)   ? {6'h00, status} :
		(i_address == adcslp_pkg::OFF_IRQ_EN)   ? {6'h00, irq_en} : 8'h00;

	// selection can move only while idle, waiting, or in the last converter clock
	wire        sel_open = (state != adcslp_pkg::ST_CONV) || (cyc_cnt == 5'd0);

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			adcslp_pkg::ST_IDLE: begin
				if (start) next_state = adcslp_pkg::ST_WAIT;
			end
			adcslp_pkg::ST_WAIT: begin
				if (tick) next_state = adcslp_pkg::ST_CONV;
			end
			adcslp_pkg::ST_CONV: begin
				if (conv_end && !free_run) next_state = adcslp_pkg::ST_IDLE;
			end
			default: next_state = adcslp_pkg::ST_IDLE;
		endcase
		if (!enable) next_state = adcslp_pkg::ST_IDLE; // disabling aborts a conversion
	end

	// bus handshake: one wait cycle, then a one-cycle answer
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= 32'h0000_0000;
		end else begin
			o_waitrequest <= !(req && o_waitrequest);
			if (req && o_waitrequest) o_readdata <= {24'h00_0000, rd_byte};
		end
	end

	// selection register, all bits read/write
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) select_reg <= adcslp_pkg::SELECT_RESET;
		else if (wr_sel) select_reg <= i_writedata[7:0];
	end

	// enable, mode and first-conversion tracking
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			enable     <= 1'b0;
			free_run   <= 1'b0;
			first_conv <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				enable   <= wd_en;
				free_run <= i_writedata[adcslp_pkg::BIT_FREE_RUN];
			end
			if (wr_ctrl && wd_en && !enable) first_conv <= 1'b1;
			else if (state == adcslp_pkg::ST_WAIT && tick) first_conv <= 1'b0;
		end
	end

	// start bit: set by software or sleep halt, cleared at single-mode completion
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start      <= 1'b0;
			sleep_conv <= 1'b0;
			halted_d   <= 1'b0;
		end else begin
			halted_d <= i_cpu_halted;
			if (wr_ctrl && !wd_en) start <= 1'b0;
			else if (user_go || sleep_go) start <= 1'b1;
			else if (conv_end && !free_run) start <= 1'b0;
			if (sleep_go) sleep_conv <= 1'b1;
			else if (conv_end || !enable) sleep_conv <= 1'b0;
		end
	end

	// prescaler, held at zero while the converter is off
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) pre_cnt <= '0;
		else if (!enable || tick) pre_cnt <= '0;
		else pre_cnt <= pre_cnt + PW'(1);
	end

	// sequencer and converter clock count
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state   <= adcslp_pkg::ST_IDLE;
			cyc_cnt <= 5'd0;
		end else begin
			state <= next_state;
			if (state == adcslp_pkg::ST_WAIT && tick) begin
				cyc_cnt <= (first_conv ? adcslp_pkg::CONV_FIRST
				                       : adcslp_pkg::CONV_NORMAL) - 5'd1;
			end else if (conv_end) begin
				cyc_cnt <= adcslp_pkg::CONV_NORMAL - 5'd1;
			end else if (state == adcslp_pkg::ST_CONV && tick) begin
				cyc_cnt <= cyc_cnt - 5'd1;
			end
		end
	end

	// result capture at completion, kept until the next completion
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) result <= 10'h000;
		else if (conv_end) result <= adcslp_format(i_sample_value,
		                                          adcslp_is_diff(o_input_gain_choice));
	end

	// channel and reference go to the core through a lock, so a mid-conversion write waits
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reference_choice  <= 2'h0;
			o_input_gain_choice <= 5'h00;
		end else if (sel_open) begin
			o_reference_choice  <= select_reg[7:6];
			o_input_gain_choice <= select_reg[4:0];
		end
	end

	// sticky status, enables and interrupt; a new event beats a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			status         <= adcslp_pkg::IRQ_RESET;
			irq_en         <= adcslp_pkg::IRQ_RESET;
			o_irq          <= 1'b0;
			o_converter_on <= 1'b0;
			o_converting   <= 1'b0;
		end else begin
			status         <= next_status;
			if (wr_en) irq_en <= i_writedata[1:0];
			o_irq          <= |(next_status & irq_en);
			o_converter_on <= enable;
			o_converting   <= (next_state == adcslp_pkg::ST_CONV);
		end
	end

endmodule : adcslp_ctrl

// [hw/adcslp_pkg.sv]
// package: register map, field positions, counts and states of the sleep converter control
// Behaviour
// - noise-reduction or idle halt with converter enabled, idle and single mode starts a conversion
// - completion of a sleep-started conversion raises the completion request regardless of wakeup
// - other sleep states leave converter enable and operating state untouched
// - after completion the result stays in the low and high result byte registers
// - single-ended result is unsigned 10-bit, 0x000 ground, 0x3ff reference minus one
// - differential result is 10-bit two's complement from 0x200 to 0x1ff
// - sign bit of a differential result is one when negative, zero otherwise
// - differential inputs beyond full scale saturate at 0x1ff or 0x200
// - left adjust puts result in upper ten bits, otherwise right aligned
// - selection register is eight bits read/write, reset zero, reference/adjust/channel fields
// - channel choices include same-channel differential pairs for offset measurement
// - normal conversion takes 13 converter clocks, first after enabling takes 25
// - completion stores result, sets done flag, clears start in single mode same cycle
// - left adjust change alters result presentation immediately
package adcslp_pkg;
	// register byte offsets on the avalon slave
	localparam logic [4:0] OFF_SELECT    = 5'h00;
	localparam logic [4:0] OFF_CONTROL   = 5'h04;
	localparam logic [4:0] OFF_RES_LOW   = 5'h08;
	localparam logic [4:0] OFF_RES_HIGH  = 5'h0c;
	localparam logic [4:0] OFF_STATUS    = 5'h10;
	localparam logic [4:0] OFF_CLEAR     = 5'h14;
	localparam logic [4:0] OFF_IRQ_EN    = 5'h18;
	// field positions
	localparam int BIT_LEFT_ADJUST = 5;
	localparam int BIT_ENABLE      = 7;
	localparam int BIT_START       = 6;
	localparam int BIT_FREE_RUN    = 5;
	localparam int BIT_DONE        = 4;
	localparam int BIT_EV_DONE     = 0;
	localparam int BIT_EV_SLEEP    = 1;
	// reset values
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET    = 2'h0;
	// sleep state encodings seen from the sleep controller
	localparam logic [2:0] SLEEP_IDLE   = 3'h0;
	localparam logic [2:0] SLEEP_NOISE  = 3'h1;
	// conversion lengths in converter clocks
	localparam logic [4:0] CONV_NORMAL = 5'd13;
	localparam logic [4:0] CONV_FIRST  = 5'd25;
	// result limits
	localparam logic signed [11:0] SE_MAX   = 12'sh3ff;
	localparam logic signed [11:0] DIFF_MAX = 12'sh1ff;
	localparam logic signed [11:0] DIFF_MIN = -12'sh200;
	// conversion sequencer, gray along idle, wait, convert
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b11
	} adcslp_state_t;
endpackage : adcslp_pkg

// [testbench/adcslp_assertions.sv]
// checker: port-level properties of the sleep converter control
module adcslp_chk #(
	parameter int PRESCALE = 2
) (
	// watched ports
	input wire logic        i_clock,
	input wire logic        i_arst_n,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	input wire logic [2:0]  i_sleep_mode,
	input wire logic        i_cpu_halted,
	input wire logic        o_converter_on,
	input wire logic        o_converting,
	input wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	logic [7:0] conv_cnt;
	// length of the convert phase; an abort would shorten it, the bench never aborts
	always_ff @(posedge i_clock or negedge i_arst_n)
		if (!i_arst_n) conv_cnt <= 8'h00;
		else conv_cnt <= o_converting ? conv_cnt + 8'h01 : 8'h00;
	property p_wait_one; (i_read || i_write) && o_waitrequest |=> !o_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
	property p_wait_pulse; !o_waitrequest |=> o_waitrequest; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
	property p_rd_upper; i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h000000; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_sleep_start; $rose(i_cpu_halted) && i_sleep_mode <= adcslp_pkg::SLEEP_NOISE
		&& o_converter_on && !o_converting |-> ##[1:8] o_converting; endproperty
	a_sleep_start: assert property (p_sleep_start) else $error("no sleep conversion");
	property p_keep_on; $rose(i_cpu_halted) && i_sleep_mode > adcslp_pkg::SLEEP_NOISE
		&& !i_write && !$past(i_write) |=> $stable(o_converter_on) [*4]; endproperty
	a_keep_on: assert property (p_keep_on) else $error("enable changed by sleep");
	property p_no_conv; $rose(i_cpu_halted) && i_sleep_mode > adcslp_pkg::SLEEP_NOISE
		&& !o_converter_on && !i_write && !$past(i_write) |=> !o_converting [*4]; endproperty
	a_no_conv: assert property (p_no_conv) else $error("conversion in other sleep");
	property p_conv_len; $fell(o_converting)
		|-> conv_cnt >= 12 * PRESCALE && conv_cnt <= 26 * PRESCALE; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_irq_cause; $rose(o_irq) && !$past(i_write) && !$past(i_write, 2)
		|-> $past(o_converting) || $past(o_converting, 2); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without completion");
endmodule : adcslp_chk

// [testbench/adcslp_partner.sv]
// partner: sleep controller halting the cpu, and the converter core level
module adcslp_partner (
	// clock, reset and bench commands
	input  wire logic               i_clock,
	input  wire logic               i_arst_n,
	input  wire logic               i_sleep_req,
	input  wire logic [2:0]         i_sleep_kind,
	input  wire logic               i_wake,
	input  wire logic signed [11:0] i_level,
	// towards the converter control
	output logic                    o_cpu_halted,
	output logic [2:0]              o_sleep_mode,
	output logic signed [11:0]      o_sample_value
);
	timeunit 1ns;
	timeprecision 1ps;
	// cpu halts on request and wakes on the completion request
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cpu_halted <= 1'b0;
			o_sleep_mode <= 3'h0;
		end else if (i_wake || !i_sleep_req) begin
			o_cpu_halted <= 1'b0;
		end else begin
			o_cpu_halted <= 1'b1;
			o_sleep_mode <= i_sleep_kind;
		end
	end
	// raw level, may exceed full scale; clamping is the control's job
	assign o_sample_value = i_level;
endmodule : adcslp_partner

// [testbench/tb_top.sv]
// testbench: register, sleep and result scenarios for the sleep converter control
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_clock, i_arst_n, i_read, i_write, sleep_req;
	logic               i_cpu_halted, o_waitrequest, o_converter_on, o_converting, o_irq;
	logic [4:0]         i_address, o_input_gain_choice;
	logic [31:0]        i_writedata, o_readdata;
	logic [2:0]         i_sleep_mode, sleep_kind;
	logic [1:0]         o_reference_choice;
	logic signed [11:0] i_sample_value, level;
	logic [7:0]         rdat;
	int                 error_cnt, checked;
	logic [7:0]         sel_t [6] = '{8'h00, 8'h00, 8'h0d, 8'h0d, 8'h08, 8'h3d};
	logic signed [11:0] lvl_t [6] = '{12'sh5dc, -12'sh005, 12'sh2bc, -12'sh384, 12'sh003, -12'sh001};
	logic [7:0]         hi_t [6]  = '{8'h03, 8'h00, 8'h01, 8'h02, 8'h00, 8'hff};
	logic [7:0]         lo_t [6]  = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h03, 8'hc0};
	adcslp_ctrl #(.PRESCALE(1)) adcslp_ctrl_inst (.i_clock, .i_arst_n, .i_address, .i_read,
		.i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_sleep_mode, .i_cpu_halted,
		.i_sample_value, .o_reference_choice, .o_input_gain_choice, .o_converter_on,
		.o_converting, .o_irq);
	adcslp_partner adcslp_partner_inst (.i_clock, .i_arst_n, .i_sleep_req(sleep_req),
		.i_sleep_kind(sleep_kind), .i_wake(o_irq), .i_level(level),
		.o_cpu_halted(i_cpu_halted), .o_sleep_mode(i_sleep_mode), .o_sample_value(i_sample_value));
	// 250 MHz
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	task automatic print_verdict(input bit hung);
		if (hung) error_cnt++;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one avalon transfer; the idle edge first keeps a release and a new request apart
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clock);
		i_address <= a;
		i_writedata <= {24'h000000, d};
		i_write <= w;
		i_read <= !w;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		rdat = o_readdata[7:0];
		i_write <= 1'b0;
		i_read <= 1'b0;
		if (n >= 50) print_verdict(1);
	endtask : bus
	task automatic rc(input logic [4:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, a, 8'h00);
		chk(what, exp, rdat);
	endtask : rc
	task automatic wait_irq();
		int n;
		n = 0;
		while (o_irq !== 1'b1 && n < 300) begin
			@(posedge i_clock);
			n++;
		end
		if (n >= 300) print_verdict(1);
	endtask : wait_irq
	// main sequence
	initial begin
		error_cnt = 0;
		checked = 0;
		i_arst_n = 1'b0;
		{i_read, i_write, sleep_req} = 3'h0;
		i_address = 5'h00;
		i_writedata = 32'h00000000;
		sleep_kind = 3'h0;
		level = 12'sh000;
		repeat (5) @(posedge i_clock);
		i_arst_n <= 1'b1;
		rc(adcslp_pkg::OFF_SELECT, 8'h00, "select reset");
		bus(1'b1, adcslp_pkg::OFF_SELECT, 8'hff);
		rc(adcslp_pkg::OFF_SELECT, 8'hff, "select rw");
		bus(1'b1, adcslp_pkg::OFF_IRQ_EN, 8'h01);
		bus(1'b1, adcslp_pkg::OFF_SELECT, 8'h2d);
		bus(1'b1, adcslp_pkg::OFF_CONTROL, 8'h80);
		level <= -12'sh190;
		sleep_kind <= adcslp_pkg::SLEEP_NOISE;
		sleep_req <= 1'b1;
		wait_irq();
		repeat (2) @(posedge i_clock);
		sleep_req <= 1'b0;
		chk("halted", 8'h00, {7'h00, i_cpu_halted});
		rc(adcslp_pkg::OFF_STATUS, 8'h03, "status");
		rc(adcslp_pkg::OFF_RES_HIGH, 8'h9c, "left high");
		rc(adcslp_pkg::OFF_RES_LOW, 8'h00, "left low");
		bus(1'b1, adcslp_pkg::OFF_SELECT, 8'h0d);
		rc(adcslp_pkg::OFF_RES_HIGH, 8'h02, "right high");
		rc(adcslp_pkg::OFF_RES_LOW, 8'h70, "right low");
		bus(1'b1, adcslp_pkg::OFF_CLEAR, 8'h03);
		repeat (2) @(posedge i_clock);
		chk("irq", 8'h00, {7'h00, o_irq});
		$display("test sleep conversion done");
		for (int k = 0; k < 6; k++) begin
			bus(1'b1, adcslp_pkg::OFF_SELECT, sel_t[k]);
			level <= lvl_t[k];
			bus(1'b1, adcslp_pkg::OFF_CONTROL, 8'hc0);
			wait_irq();
			rc(adcslp_pkg::OFF_RES_HIGH, hi_t[k], "table high");
			rc(adcslp_pkg::OFF_RES_LOW, lo_t[k], "table low");
			bus(1'b1, adcslp_pkg::OFF_CLEAR, 8'h03);
			repeat (2) @(posedge i_clock);
		end
		$display("test result codes done");
		sleep_kind <= 3'h2;
		sleep_req <= 1'b1;
		repeat (40) @(posedge i_clock);
		sleep_req <= 1'b0;
		chk("kept on", 8'h01, {7'h00, o_converter_on});
		rc(adcslp_pkg::OFF_STATUS, 8'h00, "no start");
		bus(1'b1, adcslp_pkg::OFF_CONTROL, 8'h00);
		sleep_req <= 1'b1;
		repeat (10) @(posedge i_clock);
		sleep_req <= 1'b0;
		rc(adcslp_pkg::OFF_STATUS, 8'h00, "still idle");
		$display("test other sleep done");
		// off then on after waking forces the long first conversion before a differential read
		bus(1'b1, adcslp_pkg::OFF_SELECT, 8'h0d);
		level <= -12'sh064;
		bus(1'b1, adcslp_pkg::OFF_CONTROL, 8'hc0);
		wait_irq();
		rc(adcslp_pkg::OFF_RES_HIGH, 8'h03, "reenable high");
		rc(adcslp_pkg::OFF_RES_LOW, 8'h9c, "reenable low");
		bus(1'b1, adcslp_pkg::OFF_CLEAR, 8'h03);
		$display("test re-enable done");
		print_verdict(0);
	end
endmodule : tb_top
bind adcslp_ctrl adcslp_chk #(.PRESCALE(PRESCALE)) adcslp_chk_inst (.i_clock, .i_arst_n,
	.i_read, .i_write, .o_readdata, .o_waitrequest, .i_sleep_mode, .i_cpu_halted,
	.o_converter_on, .o_converting, .o_irq);
